/* File: bench/wpl_link_partner.sv */
// link partner model: delivers received frames byte by byte
// assumes the bench calls send and set_line; drives 1 ns after ref_clk
`timescale 1ns/100ps
`default_nettype none
module wpl_link_partner (
  input  wire logic       ref_clk,
  output logic            rx_sof,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_eof,
  output logic            rx_crc_ok,
  output logic            energy_det,
  output logic            partner_det
);
  // quiet line, cable present, no partner yet
  initial begin
    rx_sof      = 1'b0;
    rx_valid    = 1'b0;
    rx_data     = 8'h5A;
    rx_eof      = 1'b0;
    rx_crc_ok   = 1'b0;
    energy_det  = 1'b1;
    partner_det = 1'b0;
  end
  // one frame: start mark, bytes (gaps model the slow line), end mark
  task automatic send(input logic [7:0] fb [0:199], input int n,
                      input logic crc, input int gap);
    int i;
    @(posedge ref_clk);
    #1 rx_sof = 1'b1;
    @(posedge ref_clk);
    #1 rx_sof = 1'b0;
    for (i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_data  = fb[i];
      @(posedge ref_clk);
      #1;
      if (gap > 0) begin
        rx_valid = 1'b0;
        rx_data  = ~fb[i];
        repeat (gap) @(posedge ref_clk);
        #1;
      end
    end
    if (gap == 0) begin
      rx_valid = 1'b0;
      rx_data  = ~rx_data;
    end
    rx_eof    = 1'b1;
    rx_crc_ok = crc;
    @(posedge ref_clk);
    #1 rx_eof = 1'b0;
    rx_crc_ok = ~crc;
  endtask
  // cable energy and partner presence
  task automatic set_line(input logic e, input logic p);
    @(posedge ref_clk);
    #1 energy_det = e;
    partner_det = p;
  endtask
endmodule
`default_nettype wire

/* File: bench/wpl_top_bench.sv */
// self-checking bench for the wake-frame and low-power controller
// assumes wpl_top, wpl_pkg and the partner model wpl_link_partner
`timescale 1ns/100ps
`default_nettype none
module wpl_top_bench
  import wpl_pkg::*;
;
  localparam int NLP = 20;
  logic        ref_clk;
  logic        rst;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        rx_sof;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_eof;
  logic        rx_crc_ok;
  logic        energy_det;
  logic        partner_det;
  logic        pd_drv;
  logic        pin_line;
  logic        intpd_pin_out;
  logic        intpd_pin_oe;
  logic        wake_pin;
  logic        nlp_send;
  logic        analog_en;
  logic        clock_en;
  logic        pll_en;
  logic [1:0]  power_state;
  int          bad_count;
  int          n_tests;
  int          n;
  int          g;
  logic [7:0]  fb [0:199];
  logic [7:0]  node [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
  logic [7:0]  pass [6] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F};
  logic [15:0] adrs [7] = '{ADR_BASIC_CTL, ADR_PHY_SPEC, ADR_ISR_TWO,
    ADR_DEEP_CTL, ADR_WAKE_CFG, ADR_WAKE_STS, 16'h0100};
  // open-drain pin with pull-up
  assign pin_line = intpd_pin_oe ? intpd_pin_out : pd_drv;
  always #25 ref_clk = ~ref_clk;
  wpl_top #(.NLP_CYCLES(NLP)) dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_sof(rx_sof),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_eof(rx_eof),
    .rx_crc_ok(rx_crc_ok), .energy_det(energy_det),
    .partner_det(partner_det), .intpd_pin_in(pin_line),
    .intpd_pin_out(intpd_pin_out), .intpd_pin_oe(intpd_pin_oe),
    .wake_pin(wake_pin), .nlp_send(nlp_send), .analog_en(analog_en),
    .clock_en(clock_en), .pll_en(pll_en), .power_state(power_state));
  wpl_link_partner lp (
    .ref_clk(ref_clk), .rx_sof(rx_sof), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok),
    .energy_det(energy_det), .partner_det(partner_det));
  // verdict and end of run
  task automatic print_verdict;
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // compare words
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp,
                         input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // compare pin levels
  task automatic chk_pin(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask
  // a bounded wait ran out
  task automatic fail_to(input string msg);
    bad_count++;
    $display("BAD %0t timeout %s", $time, msg);
    print_verdict();
  endtask
  // management write and checked read
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1 reg_wr = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk);
    #1 reg_rd = 1'b0;
    chk_pin(reg_rvalid, 1'b1, "read valid");
    chk_reg(reg_rdata, e, $sformatf("read %h", a));
  endtask
  // frame builder
  task automatic put(input logic [7:0] b);
    fb[n] = b;
    n++;
  endtask
  task automatic mk(input int dst, input bit brk, input int cps,
                    input int pw);
    int i;
    int k;
    n = 0;
    for (i = 0; i < 6; i++) put(dst == 1 ? 8'hFF : dst == 2 ? 8'h5A : node[i]);
    for (i = 0; i < 6; i++) put(8'hA0 + 8'(i));
    put(8'h00);
    put(8'hFF);
    put(8'hFF);
    put(8'h08);
    if (brk) begin
      for (i = 0; i < 6; i++) put(8'hFF);
      for (k = 0; k < 18; k++) put(node[k % 6]);
      put(8'h00);
    end
    for (i = 0; i < 6; i++) put(8'hFF);
    for (k = 0; k < cps * 6; k++) put(node[k % 6]);
    for (i = 0; i < 6 && pw > 0; i++) put(pw == 2 && i == 5 ? 8'h00 : pass[i]);
  endtask
  // send a frame, watch the wake pin, read and clear the status
  task automatic run(input int dst, input bit brk, input int cps,
                     input int pw, input logic crc, input int gap,
                     input logic [15:0] st, input int pulses);
    int i;
    int cnt;
    mk(dst, brk, cps, pw);
    lp.send(fb, n, crc, gap);
    cnt = 0;
    for (i = 0; i < 6; i++) begin
      if (wake_pin === 1'b1) cnt++;
      @(posedge ref_clk);
      #1;
    end
    if (pulses >= 0)
      chk_reg(cnt[15:0], pulses[15:0], "wake cycles");
    else
      chk_pin(wake_pin, 1'b1, "wake level");
    rd(ADR_WAKE_STS, st);
  endtask
  // wait for a power state, then check the enables
  task automatic pw_chk(input logic [1:0] st, input logic [2:0] en);
    int i;
    i = 0;
    while (power_state !== st && i < 8) begin
      @(posedge ref_clk);
      #1 i++;
    end
    if (i == 8) fail_to("power state");
    chk_reg({13'h0, analog_en, clock_en, pll_en}, {13'h0, en}, "enables");
  endtask
  // spacing of link pulses
  task automatic nlp_gap(output int gap);
    int i;
    for (i = 0; i < 3 * NLP && nlp_send !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (i == 3 * NLP) fail_to("link pulse");
    gap = 0;
    do begin
      @(posedge ref_clk);
      #1 gap++;
    end while (nlp_send !== 1'b1 && gap < 3 * NLP);
  endtask
  // main sequence
  initial begin
    ref_clk   = 1'b0;
    rst       = 1'b1;
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    pd_drv    = 1'b1;
    bad_count = 0;
    n_tests   = 0;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    foreach (adrs[i]) rd(adrs[i], 16'h0000);
    wr(ADR_NODE0, 16'h2211);
    wr(ADR_NODE1, 16'h4433);
    wr(ADR_NODE2, 16'h6655);
    wr(ADR_PASS0, 16'h2B2A);
    wr(ADR_PASS1, 16'h2D2C);
    wr(ADR_PASS2, 16'h2F2E);
    rd(ADR_PASS0, 16'h0000);
    wr(ADR_WAKE_STS, 16'h0003);
    rd(ADR_WAKE_STS, 16'h0000);
    wr(ADR_ISR_TWO, 16'h0002);
    wr(ADR_WAKE_CFG, 16'h0011);
    run(0, 0, 16, 0, 1'b1, 0, 16'h0001, 1);
    chk_pin(intpd_pin_oe, 1'b1, "irq pin");
    chk_pin(intpd_pin_out, 1'b0, "irq pin level");
    rd(ADR_ISR_TWO, 16'h0202);
    repeat (2) @(posedge ref_clk);
    chk_pin(intpd_pin_oe, 1'b0, "irq pin clear");
    run(0, 0, 16, 0, 1'b0, 0, 16'h0002, 0);
    run(0, 0, 15, 0, 1'b1, 0, 16'h0000, 0);
    run(0, 1, 16, 0, 1'b1, 0, 16'h0001, 1);
    run(0, 1, 16, 0, 1'b1, 4, 16'h0001, 1);
    run(2, 0, 16, 0, 1'b1, 0, 16'h0000, 0);
    run(1, 0, 16, 0, 1'b1, 0, 16'h0000, 0);
    wr(ADR_WAKE_CFG, 16'h0013);
    run(1, 0, 16, 0, 1'b1, 0, 16'h0001, 1);
    wr(ADR_WAKE_CFG, 16'h0015);
    run(0, 0, 16, 1, 1'b1, 0, 16'h0001, 1);
    run(0, 0, 16, 2, 1'b1, 0, 16'h0000, 0);
    run(0, 0, 16, 0, 1'b1, 0, 16'h0000, 0);
    wr(ADR_WAKE_CFG, 16'h0019);
    run(0, 0, 16, 0, 1'b1, 0, 16'h0001, -1);
    repeat (2) @(posedge ref_clk);
    chk_pin(wake_pin, 1'b0, "level cleared");
    wr(ADR_WAKE_CFG, 16'h0000);
    run(0, 0, 16, 0, 1'b1, 0, 16'h0000, 0);
    lp.set_line(1'b0, 1'b0);
    wr(ADR_PHY_SPEC, 16'h5000);
    repeat (6) @(posedge ref_clk);
    chk_reg({14'h0, power_state}, 16'h0000, "no sleep");
    wr(ADR_PHY_SPEC, 16'h6000);
    pw_chk(P_SLEEP, 3'b011);
    nlp_gap(g);
    chk_reg(g[15:0], NLP[15:0], "pulse gap");
    lp.set_line(1'b1, 1'b1);
    pw_chk(P_NORM, 3'b111);
    wr(ADR_PHY_SPEC, 16'h0000);
    lp.set_line(1'b1, 1'b0);
    wr(ADR_BASIC_CTL, 16'h0800);
    pw_chk(P_IEEE, 3'b011);
    wr(ADR_BASIC_CTL, 16'h0000);
    pw_chk(P_NORM, 3'b111);
    wr(ADR_PHY_SPEC, 16'h0001);
    pd_drv = 1'b0;
    pw_chk(P_IEEE, 3'b011);
    pd_drv = 1'b1;
    pw_chk(P_NORM, 3'b111);
    wr(ADR_DEEP_CTL, 16'h0004);
    wr(ADR_BASIC_CTL, 16'h0800);
    pw_chk(P_DEEP, 3'b000);
    chk_reg({14'h0, power_state}, 16'h0002, "deep state");
    wr(ADR_BASIC_CTL, 16'h0000);
    pw_chk(P_NORM, 3'b111);
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: design/wpl_pkg.sv */
// constants of the wake-frame and low-power controller
// assumes a 20 MHz reference clock and a decoded management port
package wpl_pkg;
  // register offsets
  localparam logic [15:0] ADR_BASIC_CTL = 16'h0000;
  localparam logic [15:0] ADR_PHY_SPEC  = 16'h0011;
  localparam logic [15:0] ADR_ISR_TWO   = 16'h0013;
  localparam logic [15:0] ADR_DEEP_CTL  = 16'h0428;
  localparam logic [15:0] ADR_WAKE_CFG  = 16'h04A0;
  localparam logic [15:0] ADR_WAKE_STS  = 16'h04A1;
  localparam logic [15:0] ADR_NODE0     = 16'h04A2;
  localparam logic [15:0] ADR_NODE1     = 16'h04A3;
  localparam logic [15:0] ADR_NODE2     = 16'h04A4;
  localparam logic [15:0] ADR_PASS0     = 16'h04A5;
  localparam logic [15:0] ADR_PASS1     = 16'h04A6;
  localparam logic [15:0] ADR_PASS2     = 16'h04A7;
  // field positions
  localparam int          PD_BIT        = 11;
  localparam int          PIN_PD_BIT    = 0;
  localparam int          SLP_HI        = 14;
  localparam int          SLP_LO        = 12;
  localparam logic [2:0]  SLP_CODE      = 3'h6;
  localparam int          WAKE_IE_BIT   = 1;
  localparam int          WAKE_IS_BIT   = 9;
  localparam int          DPD_BIT       = 2;
  localparam int          CFG_EN_BIT    = 0;
  localparam int          CFG_BC_BIT    = 1;
  localparam int          CFG_SEC_BIT   = 2;
  localparam int          CFG_LVL_BIT   = 3;
  localparam int          CFG_PIN_BIT   = 4;
  localparam int          STS_WAKE_BIT  = 0;
  localparam int          STS_CRC_BIT   = 1;
  // reset values
  localparam logic [15:0] REG_RST       = 16'h0000;
  // pattern figures
  localparam logic [7:0]  SYNC_BYTE     = 8'hFF;
  localparam logic [2:0]  SYNC_LEN      = 3'h6;
  localparam logic [2:0]  LAST_POS      = 3'h5;
  localparam logic [3:0]  LAST_COPY     = 4'hF;
  // link pulse interval in active sleep
  localparam int          NLP_MS        = 1400;
  localparam int          CLK_KHZ       = 20000;
  localparam int          NLP_CYC_DEF   = NLP_MS * CLK_KHZ;
  localparam int          NLP_W         = 25;
  typedef enum logic [1:0] {
    M_SYNC  = 2'h0,
    M_ADDR  = 2'h1,
    M_PASS  = 2'h3,
    M_FOUND = 2'h2
  } wpl_match_t;
  typedef enum logic [1:0] {
    P_NORM  = 2'h0,
    P_SLEEP = 2'h1,
    P_IEEE  = 2'h3,
    P_DEEP  = 2'h2
  } wpl_pwr_t;
endpackage

/* File: design/wpl_top.sv */
// wake-frame detector and low-power state control
// assumes byte-wide receive data and a decoded management port,
// both synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module wpl_top
  import wpl_pkg::*;
#(
  parameter int NLP_CYCLES = NLP_CYC_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        rx_sof,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_eof,
  input  wire logic        rx_crc_ok,
  input  wire logic        energy_det,
  input  wire logic        partner_det,
  input  wire logic        intpd_pin_in,
  output logic             intpd_pin_out,
  output logic             intpd_pin_oe,
  output logic             wake_pin,
  output logic             nlp_send,
  output logic             analog_en,
  output logic             clock_en,
  output logic             pll_en,
  output logic      [1:0]  power_state
);

  typedef struct packed {
    logic [15:0]      bc;
    logic [15:0]      psc;
    logic             ie;
    logic             is;
    logic [15:0]      dpc;
    logic [15:0]      cfg;
    logic [47:0]      node;
    logic [47:0]      pass;
    logic             wk;
    logic             crcb;
    wpl_match_t       ms;
    logic [2:0]       pos;
    logic [3:0]       copy;
    logic [2:0]       sync;
    logic [2:0]       dpos;
    logic             duc;
    logic             dbc;
    wpl_pwr_t         pw;
    logic [NLP_W-1:0] cnt;
    logic             nlp;
    logic             wpin;
    logic [15:0]      rdata;
    logic             rvalid;
    logic             ana;
    logic             clk;
    logic             intoe;
  } wpl_state_t;

  localparam logic [NLP_W-1:0] NLP_LAST = NLP_W'(NLP_CYCLES - 1);

  wpl_state_t r_reg;
  wpl_state_t r_next;
  logic       pd_req;
  logic       sleep_en;
  logic       deep_power_down;
  logic       ev;
  logic [7:0] exp_b;
  logic [7:0] pas_b;
  logic [7:0] dst_b;

  // decoded controls and the bytes expected next
  assign pd_req   = r_reg.bc[PD_BIT]
                  | (r_reg.psc[PIN_PD_BIT] & ~intpd_pin_in);
  assign sleep_en = r_reg.psc[SLP_HI:SLP_LO] == SLP_CODE;
  assign deep_power_down      = r_reg.dpc[DPD_BIT];
  assign exp_b    = r_reg.node[{r_reg.pos, 3'h0} +: 8];
  assign pas_b    = r_reg.pass[{r_reg.pos, 3'h0} +: 8];
  assign dst_b    = r_reg.node[{r_reg.dpos, 3'h0} +: 8];

  // wake event at frame end: pattern, destination and CRC all good
  assign ev = rx_eof && rx_crc_ok && r_reg.ms == M_FOUND
           && r_reg.dpos == SYNC_LEN
           && (r_reg.duc || (r_reg.dbc && r_reg.cfg[CFG_BC_BIT]));

  // next state of the whole block
  always_comb begin
    r_next        = r_reg;
    r_next.rvalid = reg_rd;
    r_next.nlp    = 1'b0;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        ADR_BASIC_CTL: r_next.bc = reg_wdata;
        ADR_PHY_SPEC:  r_next.psc = reg_wdata;
        ADR_ISR_TWO:   r_next.ie = reg_wdata[WAKE_IE_BIT];
        ADR_DEEP_CTL:  r_next.dpc = reg_wdata;
        ADR_WAKE_CFG:  r_next.cfg = reg_wdata;
        ADR_NODE0:     r_next.node[15:0] = reg_wdata;
        ADR_NODE1:     r_next.node[31:16] = reg_wdata;
        ADR_NODE2:     r_next.node[47:32] = reg_wdata;
        ADR_PASS0:     r_next.pass[15:0] = reg_wdata;
        ADR_PASS1:     r_next.pass[31:16] = reg_wdata;
        ADR_PASS2:     r_next.pass[47:32] = reg_wdata;
        default: ;
      endcase
    end
    // register reads, status cleared by reading it
    r_next.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        ADR_BASIC_CTL: r_next.rdata = r_reg.bc;
        ADR_PHY_SPEC:  r_next.rdata = r_reg.psc;
        ADR_ISR_TWO: begin
          r_next.rdata[WAKE_IE_BIT] = r_reg.ie;
          r_next.rdata[WAKE_IS_BIT] = r_reg.is;
          r_next.is = 1'b0;
        end
        ADR_DEEP_CTL:  r_next.rdata = r_reg.dpc;
        ADR_WAKE_CFG:  r_next.rdata = r_reg.cfg;
        ADR_WAKE_STS: begin
          r_next.rdata[STS_WAKE_BIT] = r_reg.wk;
          r_next.rdata[STS_CRC_BIT]  = r_reg.crcb;
          r_next.wk   = 1'b0;
          r_next.crcb = 1'b0;
          if (r_reg.cfg[CFG_LVL_BIT]) begin
            r_next.wpin = 1'b0;
          end
        end
        ADR_NODE0:     r_next.rdata = r_reg.node[15:0];
        ADR_NODE1:     r_next.rdata = r_reg.node[31:16];
        ADR_NODE2:     r_next.rdata = r_reg.node[47:32];
        default: ;
      endcase
    end
    // frame start clears matcher and destination check
    if (rx_sof) begin
      r_next.ms   = M_SYNC;
      r_next.sync = 3'h0;
      r_next.pos  = 3'h0;
      r_next.copy = 4'h0;
      r_next.dpos = 3'h0;
      r_next.duc  = 1'b1;
      r_next.dbc  = 1'b1;
    end else if (rx_valid) begin
      // destination: first six bytes, own or broadcast
      if (r_reg.dpos != SYNC_LEN) begin
        r_next.duc  = r_reg.duc && rx_data == dst_b;
        r_next.dbc  = r_reg.dbc && rx_data == SYNC_BYTE;
        r_next.dpos = r_reg.dpos + 3'h1;
      end
      // byte-wise pattern search, any offset, any line speed
      if (r_reg.cfg[CFG_EN_BIT]) begin
        case (r_reg.ms)
          M_SYNC: begin
            if (r_reg.sync == SYNC_LEN && rx_data == exp_b) begin
              r_next.ms  = M_ADDR;
              r_next.pos = 3'h1;
            end else if (rx_data == SYNC_BYTE) begin
              if (r_reg.sync != SYNC_LEN) begin
                r_next.sync = r_reg.sync + 3'h1;
              end
            end else begin
              r_next.sync = 3'h0;
            end
          end
          M_ADDR: begin
            if (rx_data == exp_b) begin
              if (r_reg.pos == LAST_POS) begin
                r_next.pos = 3'h0;
                if (r_reg.copy == LAST_COPY) begin
                  r_next.ms = r_reg.cfg[CFG_SEC_BIT] ? M_PASS : M_FOUND;
                end else begin
                  r_next.copy = r_reg.copy + 4'h1;
                end
              end else begin
                r_next.pos = r_reg.pos + 3'h1;
              end
            end else begin
              r_next.ms   = M_SYNC;
              r_next.sync = {2'h0, rx_data == SYNC_BYTE};
              r_next.pos  = 3'h0;
              r_next.copy = 4'h0;
            end
          end
          M_PASS: begin
            if (rx_data == pas_b) begin
              if (r_reg.pos == LAST_POS) begin
                r_next.ms = M_FOUND;
              end else begin
                r_next.pos = r_reg.pos + 3'h1;
              end
            end else begin
              r_next.ms   = M_SYNC;
              r_next.sync = {2'h0, rx_data == SYNC_BYTE};
              r_next.pos  = 3'h0;
              r_next.copy = 4'h0;
            end
          end
          M_FOUND: ;
          default: r_next.ms = M_SYNC;
        endcase
      end
    end else if (rx_eof) begin
      r_next.ms = M_SYNC;
      if (r_reg.ms == M_FOUND && !rx_crc_ok) begin
        r_next.crcb = 1'b1;
      end
    end
    // wake event; set wins over a clear by read
    if (pulse_mode()) begin
      r_next.wpin = ev && r_reg.cfg[CFG_PIN_BIT];
    end
    if (ev) begin
      r_next.wk = 1'b1;
      r_next.is = 1'b1;
      if (r_reg.cfg[CFG_PIN_BIT]) begin
        r_next.wpin = 1'b1;
      end
    end
    // power state
    case (r_reg.pw)
      P_NORM: begin
        if (pd_req) begin
          r_next.pw = deep_power_down ? P_DEEP : P_IEEE;
        end else if (sleep_en && !energy_det) begin
          r_next.pw = P_SLEEP;
        end
      end
      P_SLEEP: begin
        if (pd_req) begin
          r_next.pw = deep_power_down ? P_DEEP : P_IEEE;
        end else if (partner_det || !sleep_en) begin
          r_next.pw = P_NORM;
        end
      end
      P_IEEE, P_DEEP: begin
        if (!pd_req) begin
          r_next.pw = P_NORM;
        end else begin
          r_next.pw = deep_power_down ? P_DEEP : P_IEEE;
        end
      end
      default: r_next.pw = P_NORM;
    endcase
    // link pulse timer, runs only while asleep
    if (r_reg.pw == P_SLEEP) begin
      if (r_reg.cnt == NLP_LAST) begin
        r_next.cnt = '0;
        r_next.nlp = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + 1'b1;
      end
    end else begin
      r_next.cnt = '0;
    end
    // power enables follow the next state
    r_next.ana   = r_next.pw == P_NORM;
    r_next.clk   = r_next.pw != P_DEEP;
    // pin released in the same cycle it turns into a power-down input
    r_next.intoe = !r_next.psc[PIN_PD_BIT] && r_next.ie && r_next.is;
  end

  function automatic logic pulse_mode();
    return !r_reg.cfg[CFG_LVL_BIT];
  endfunction

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_reg      <= '0;
      r_reg.bc   <= REG_RST;
      r_reg.psc  <= REG_RST;
      r_reg.dpc  <= REG_RST;
      r_reg.cfg  <= REG_RST;
      r_reg.ms   <= M_SYNC;
      r_reg.pw   <= P_NORM;
      r_reg.ana  <= 1'b1;
      r_reg.clk  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register, except intpd_pin_out, which is tied low
  assign reg_rdata     = r_reg.rdata;
  assign reg_rvalid    = r_reg.rvalid;
  assign intpd_pin_out = 1'b0; // open drain, low when asserted
  assign intpd_pin_oe  = r_reg.intoe;
  assign wake_pin      = r_reg.wpin;
  assign nlp_send      = r_reg.nlp;
  assign analog_en     = r_reg.ana;
  assign clock_en      = r_reg.clk;
  assign pll_en        = r_reg.clk;
  assign power_state   = r_reg.pw;

  // checks
  property p_pd_bit;
    @(posedge ref_clk) disable iff (rst)
    (r_reg.bc[PD_BIT] && !deep_power_down) |=> power_state == P_IEEE && !analog_en;
  endproperty
  a_pd_bit: assert property (p_pd_bit)
    else $error("power-down bit did not reach IEEE power-down");
  property p_pd_pin;
    @(posedge ref_clk) disable iff (rst)
    (r_reg.psc[PIN_PD_BIT] && !intpd_pin_in && !deep_power_down)
      |=> power_state == P_IEEE && clock_en;
  endproperty
  a_pd_pin: assert property (p_pd_pin)
    else $error("low power-down pin did not reach IEEE power-down");
  property p_deep;
    @(posedge ref_clk) disable iff (rst)
    (pd_req && deep_power_down) |=> power_state == P_DEEP && !pll_en && !clock_en;
  endproperty
  a_deep: assert property (p_deep)
    else $error("deep power-down did not stop the PLL");
  property p_sleep_in;
    @(posedge ref_clk) disable iff (rst)
    (power_state == P_NORM && sleep_en && !energy_det && !pd_req)
      |=> power_state == P_SLEEP;
  endproperty
  a_sleep_in: assert property (p_sleep_in)
    else $error("active sleep not entered");
  property p_sleep_out;
    @(posedge ref_clk) disable iff (rst)
    (power_state == P_SLEEP && partner_det && !pd_req)
      |=> power_state == P_NORM && analog_en;
  endproperty
  a_sleep_out: assert property (p_sleep_out)
    else $error("partner did not wake the block");
  property p_nlp;
    @(posedge ref_clk) disable iff (rst)
    nlp_send |-> $past(power_state) == P_SLEEP && r_reg.cnt == '0;
  endproperty
  a_nlp: assert property (p_nlp)
    else $error("link pulse outside active sleep");
  property p_crc;
    @(posedge ref_clk) disable iff (rst)
    $rose(r_reg.wk) |-> $past(rx_eof && rx_crc_ok);
  endproperty
  a_crc: assert property (p_crc)
    else $error("wake status set without a good frame end");
  property p_found;
    @(posedge ref_clk) disable iff (rst)
    (rx_valid && !rx_sof && r_reg.cfg[CFG_EN_BIT]
     && r_reg.ms == M_ADDR && rx_data == exp_b
     && r_reg.pos == LAST_POS && r_reg.copy == LAST_COPY
     && !r_reg.cfg[CFG_SEC_BIT]) |=> r_reg.ms == M_FOUND;
  endproperty
  a_found: assert property (p_found)
    else $error("sixteenth copy not recognised");
  property p_pulse;
    @(posedge ref_clk) disable iff (rst)
    (wake_pin && !r_reg.cfg[CFG_LVL_BIT] && !ev) |=> !wake_pin;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("wake pulse longer than one cycle");
  c_wake: cover property (@(posedge ref_clk) disable iff (rst) ev);
  c_sleep: cover property (@(posedge ref_clk) disable iff (rst)
    power_state == P_SLEEP ##1 nlp_send);
  c_deep: cover property (@(posedge ref_clk) disable iff (rst)
    power_state == P_DEEP);
  c_crcb: cover property (@(posedge ref_clk) disable iff (rst)
    $rose(r_reg.crcb));

endmodule
`default_nettype wire
